// [hdl/clock_divider.sv]
`timescale 1ns/1ps
`default_nettype none
// free counter giving shift clock level, edge pulses and frame start pulse
module clock_divider #(
	parameter int FRAME = 512,
	parameter int DIV   = 8
) (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic run_i,      // low clears the counter
	output logic      sclk_o,     // shift clock level
	output logic      rise_o,     // one-cycle pulse before sclk rises
	output logic      fall_o,     // one-cycle pulse before sclk falls
	output logic      frame_o     // pulse at frame start
);
	localparam int CW = $clog2(FRAME);
	logic [CW-1:0] cnt_reg;        // position inside frame
	localparam logic [CW-1:0] LAST = CW'(FRAME - 1);
	localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);
	localparam logic [CW-1:0] FULL = CW'(DIV - 1);
	logic [CW-1:0] sub;
	assign sub = cnt_reg & FULL;
	// count master clocks, wrap once a frame
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
		end else if (!run_i) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
		end
	end
	// shift clock: low first half, high second half of each period
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_o <= 1'b0;
		end else begin
			sclk_o <= run_i && (sub > HALF);
		end
	end
	assign rise_o  = run_i && (sub == HALF);
	assign fall_o  = run_i && (sub == FULL);
	assign frame_o = run_i && (cnt_reg == LAST);
	a_frame_period: assert property (@(posedge mclk_i) disable iff (rst_i)
		frame_o && run_i |=> !frame_o [*8]) else $error("frame pulse too frequent");
endmodule
`default_nettype wire

// [hdl/codec_serial_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "codec_port_params.svh"
// device side of the codec serial port
module codec_serial_port
	import codec_port_pkg::*;
#(
	parameter int WORD  = `WORD_BITS,
	parameter int FRAME = `FRAME_LEN,
	parameter int DIV   = `SCLK_DIV
) (
	input  wire logic            mclk_i,
	input  wire logic            rst_i,
	input  wire logic            sleep_pin_n_i,        // power-down pin, low sleeps
	input  wire logic            data_in_i,            // host serial data
	input  wire logic            function_code_in_i,   // secondary request code
	input  wire logic            alternate_out_source_i,
	input  wire logic [WORD-1:0] adc_sample_i,         // sample to send
	input  wire logic            phone_mode_i,         // control bit: phone mode
	input  wire logic [1:0]      flag_bits_i,          // control bits for flags
	output logic                 frame_sync_n_o,
	output logic                 sclk_o,
	output logic                 data_out_o,
	output logic                 data_out_oe_o,        // high while driving
	output logic [WORD-1:0]      dac_sample_o,         // last received word
	output logic                 dac_valid_o,          // pulse with new word
	output logic                 secondary_req_o,      // latched request
	output logic [1:0]           flag_o
);
	// three-stage synchronisers for pins
	logic [2:0] sl_sync, din_sync, fc_sync, alt_sync;
	logic       sleep_ok_reg;       // filtered power-down level
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sl_sync  <= 3'h0;
			din_sync <= 3'h0;
			fc_sync  <= 3'h0;
			alt_sync <= 3'h0;
		end else begin
			sl_sync  <= {sl_sync[1:0], sleep_pin_n_i};
			din_sync <= {din_sync[1:0], data_in_i};
			fc_sync  <= {fc_sync[1:0], function_code_in_i};
			alt_sync <= {alt_sync[1:0], alternate_out_source_i};
		end
	end
	// a change counts once stages two and three agree
	logic din_s_reg, fc_s_reg, alt_s_reg;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sleep_ok_reg <= 1'b0;
			din_s_reg    <= 1'b0;
			fc_s_reg     <= 1'b0;
			alt_s_reg    <= 1'b0;
		end else begin
			if (sl_sync[1] == sl_sync[2]) sleep_ok_reg <= sl_sync[2];
			if (din_sync[1] == din_sync[2]) din_s_reg <= din_sync[2];
			if (fc_sync[1] == fc_sync[2]) fc_s_reg <= fc_sync[2];
			if (alt_sync[1] == alt_sync[2]) alt_s_reg <= alt_sync[2];
		end
	end

	logic rise, fall, frame_start;
	clock_divider #(.FRAME(FRAME), .DIV(DIV)) u_div (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.run_i   (sleep_ok_reg),
		.sclk_o  (sclk_o),
		.rise_o  (rise),
		.fall_o  (fall),
		.frame_o (frame_start)
	);

	localparam int BW = $clog2(WORD + 1);
	port_state_t     state_reg;
	logic [BW-1:0]   bit_cnt_reg;      // bits left in word
	logic [WORD-1:0] tx_reg;           // outgoing shift register
	logic [WORD-1:0] rx_reg;           // incoming shift register
	logic            second_reg;       // current frame is secondary
	// frame sequencer; starts shifting at next falling shift clock edge
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg   <= ST_IDLE;
			bit_cnt_reg <= '0;
		end else if (!sleep_ok_reg) begin
			state_reg   <= ST_IDLE;
			bit_cnt_reg <= '0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (frame_start) state_reg <= ST_GAP;
				end
				ST_GAP: begin
					if (fall) begin
						state_reg   <= ST_SHIFT;
						bit_cnt_reg <= BW'(WORD);
					end
				end
				ST_SHIFT: begin
					// frame sync stays low until all bits done
					if (fall && bit_cnt_reg == BW'(1)) state_reg <= ST_IDLE;
					else if (fall) bit_cnt_reg <= bit_cnt_reg - 1'b1;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	assign frame_sync_n_o = !(state_reg == ST_SHIFT);
	assign data_out_oe_o  = (state_reg == ST_SHIFT);

	// transmit shifting on falling edges, msb first
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_reg <= `SAMPLE_RESET;
		end else if (state_reg == ST_GAP && fall) begin
			tx_reg <= adc_sample_i;
		end else if (state_reg == ST_SHIFT && fall) begin
			tx_reg <= {tx_reg[WORD-2:0], 1'b0};
		end
	end
	// output bit: alternate pin in phone-mode secondary frames
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			data_out_o <= 1'b0;
		end else if (second_reg && phone_mode_i) begin
			data_out_o <= alt_s_reg;
		end else begin
			data_out_o <= (state_reg == ST_SHIFT) ? tx_reg[WORD-1] : 1'b0;
		end
	end
	// receive on rising shift clock edges
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_reg <= `SAMPLE_RESET;
		end else if (state_reg == ST_SHIFT && rise) begin
			rx_reg <= {rx_reg[WORD-2:0], din_s_reg};
		end
	end
	// hand received word out at frame end
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			dac_sample_o <= `SAMPLE_RESET;
			dac_valid_o  <= 1'b0;
		end else begin
			dac_valid_o <= 1'b0;
			if (state_reg == ST_SHIFT && fall && bit_cnt_reg == BW'(1)) begin
				dac_sample_o <= rx_reg;
				dac_valid_o  <= 1'b1;
			end
		end
	end
	// function code latched as frame sync rises; marks next frame secondary unless this frame was secondary
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			secondary_req_o <= 1'b0;
			second_reg      <= 1'b0;
		end else if (!sleep_ok_reg) begin
			second_reg <= 1'b0;
		end else begin
			if (state_reg == ST_SHIFT && fall && bit_cnt_reg == BW'(1)) begin
				secondary_req_o <= fc_s_reg;
				second_reg      <= fc_s_reg && !second_reg;
			end
		end
	end
	// flags mirror control bits while phone mode is on
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_o <= `FLAGS_RESET;
		end else if (phone_mode_i) begin
			flag_o <= flag_bits_i;
		end
	end

	sequence s_word;
		!frame_sync_n_o [*8];
	endsequence
	a_fs_word_low: assert property (@(posedge mclk_i) disable iff (rst_i)
		$fell(frame_sync_n_o) |-> s_word) else $error("frame sync too short");
	a_oe_follows_fs: assert property (@(posedge mclk_i) disable iff (rst_i)
		data_out_oe_o == !frame_sync_n_o) else $error("output enable mismatch");
	a_sleep_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
		!sleep_ok_reg |=> frame_sync_n_o) else $error("frame during sleep");
	a_flag_mirror: assert property (@(posedge mclk_i) disable iff (rst_i)
		phone_mode_i |=> flag_o == $past(flag_bits_i)) else $error("flag mismatch");
	a_valid_at_end: assert property (@(posedge mclk_i) disable iff (rst_i)
		dac_valid_o |-> $rose(frame_sync_n_o)) else $error("valid off frame end");
	a_fc_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
		dac_valid_o |-> secondary_req_o == $past(fc_s_reg)) else $error("fc not latched");
	a_no_fs_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
		frame_start |=> frame_sync_n_o) else $error("fs low at frame start");
	a_tx_msb: assert property (@(posedge mclk_i) disable iff (rst_i)
		$fell(frame_sync_n_o) && !(second_reg && phone_mode_i) |=>
		data_out_o == $past(tx_reg[WORD-1])) else $error("msb not sent");
endmodule
`default_nettype wire

// [pkg/codec_port_params.svh]
// Overview of operation
// - port active only while frame sync low
// - frame sync low for whole word transfer
// - serial output high impedance outside frames
// - shift sample bits out with shift clock
// - capture host input bits with shift clock
// - latch function code at frame sync rise
// - phone mode routes alternate pin during secondary
// - phone mode drives flags from control bits
// - one frame every 512 master clocks
// - samples are 16-bit two's complement
// - all timing from the master clock
// - shift clock divided from master clock
// - sleep pin clears counters, sequencer state, secondary mark, shift clock and serial output, keeps other registers
// - reset returns registers to defaults
`ifndef CODEC_PORT_PARAMS_SVH
`define CODEC_PORT_PARAMS_SVH
`define FRAME_LEN      512
`define WORD_BITS      16
`define SCLK_DIV       8
`define FLAGS_RESET    2'h0
`define SAMPLE_RESET   16'h0000
`endif

// [pkg/codec_port_pkg.sv]
package codec_port_pkg;
	// frame sequencer phases
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_GAP   = 2'b10
	} port_state_t;
endpackage

// [tb/codec_serial_port_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module codec_serial_port_bench;
	logic        mclk_i, rst_i, sleep_pin_n_i, data_in_i, fc_i, alt_i, phone_i;
	logic [15:0] adc_i, host_word, host_rx, dac_o;
	logic [1:0]  flag_bits_i, flag_o;
	logic        fs_n, sclk, dout, dout_oe, dac_valid, sec_req;
	int          n_errors, compares, fs_low, gap, i;
	codec_serial_port DUT (.mclk_i(mclk_i), .rst_i(rst_i), .sleep_pin_n_i(sleep_pin_n_i),
		.data_in_i(data_in_i), .function_code_in_i(fc_i), .alternate_out_source_i(alt_i),
		.adc_sample_i(adc_i), .phone_mode_i(phone_i), .flag_bits_i(flag_bits_i),
		.frame_sync_n_o(fs_n), .sclk_o(sclk), .data_out_o(dout), .data_out_oe_o(dout_oe),
		.dac_sample_o(dac_o), .dac_valid_o(dac_valid), .secondary_req_o(sec_req),
		.flag_o(flag_o));
	host_dsp_model HOST (.mclk_i(mclk_i), .frame_sync_n_i(fs_n), .sclk_i(sclk),
		.data_out_i(dout), .data_out_oe_i(dout_oe), .tx_word_i(host_word),
		.data_in_o(data_in_i), .rx_word_o(host_rx));
	// 50 ns master clock
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	task automatic end_of_test();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// wait for the word-done pulse, counting frame sync low time and cycles spent
	task automatic wait_frame();
		fs_low = 0;
		gap = 1;
		@(posedge mclk_i);
		#1;
		while (gap < 1200 && dac_valid !== 1'b1) begin
			@(posedge mclk_i);
			#1;
			gap++;
			if (fs_n === 1'b0) fs_low++;
		end
		if (dac_valid !== 1'b1) begin
			n_errors++;
			end_of_test();
		end
	endtask
	// output enable must follow frame sync at every cycle
	always @(negedge mclk_i) if (!rst_i) check({15'h0, dout_oe}, {15'h0, ~fs_n});
	// two frames back to back with near-boundary two's complement words
	task automatic s_exchange();
		@(posedge mclk_i);
		adc_i <= 16'h8001;
		host_word <= 16'h7FFE;
		wait_frame();
		wait_frame();
		check(16'(gap), 16'h0200);
		check(16'(fs_low), 16'h0080);
		check(dac_o, 16'h7FFE);
		check(host_rx, 16'h8001);
	endtask
	// function code request, then a secondary frame in phone mode
	task automatic s_secondary();
		@(posedge mclk_i);
		fc_i <= 1'b1;
		wait_frame();
		check({15'h0, sec_req}, 16'h0001);
		@(posedge mclk_i);
		fc_i <= 1'b0;
		phone_i <= 1'b1;
		alt_i <= 1'b1;
		flag_bits_i <= 2'h2;
		wait_frame();
		check(host_rx, 16'hFFFF);
		check({15'h0, sec_req}, 16'h0000);
		check({14'h0, flag_o}, 16'h0002);
		@(posedge mclk_i);
		phone_i <= 1'b0;
		alt_i <= 1'b0;
		flag_bits_i <= 2'h1;
	endtask
	// sleep in mid-frame: port stops, flags kept, traffic resumes afterwards
	task automatic s_sleep();
		for (i = 0; i < 600 && fs_n !== 1'b0; i++) @(posedge mclk_i);
		// a frame that never starts counts as a mismatch here
		check({15'h0, fs_n}, 16'h0000);
		repeat (20) @(posedge mclk_i);
		sleep_pin_n_i <= 1'b0;
		repeat (8) @(posedge mclk_i);
		fs_low = 0;
		for (i = 0; i < 700; i++) begin
			@(posedge mclk_i);
			#1;
			if (fs_n !== 1'b1) fs_low++;
		end
		check(16'(fs_low), 16'h0000);
		check({14'h0, flag_o}, 16'h0002);
		@(posedge mclk_i);
		host_word <= 16'hC35A;
		sleep_pin_n_i <= 1'b1;
		wait_frame();
		wait_frame();
		check(dac_o, 16'hC35A);
	endtask
	initial begin
		{rst_i, sleep_pin_n_i} = 2'b11;
		{fc_i, alt_i, phone_i, flag_bits_i} = 5'h00;
		adc_i = 16'h0000;
		host_word = 16'h0000;
		n_errors = 0;
		compares = 0;
		repeat (4) @(posedge mclk_i);
		#1;
		check({14'h0, fs_n, dout_oe}, 16'h0002);
		check({14'h0, flag_o}, 16'h0000);
		@(posedge mclk_i);
		rst_i <= 1'b0;
		s_exchange();
		s_secondary();
		s_sleep();
		end_of_test();
	end
endmodule
`default_nettype wire

// [tb/host_dsp_model.sv]
`timescale 1ns/1ps
`default_nettype none
// host dsp serial port: sends one word per frame, collects the device's word
module host_dsp_model (
	input  wire logic        mclk_i,
	input  wire logic        frame_sync_n_i,
	input  wire logic        sclk_i,
	input  wire logic        data_out_i,
	input  wire logic        data_out_oe_i,
	input  wire logic [15:0] tx_word_i,     // word sent to the device
	output logic             data_in_o,
	output logic [15:0]      rx_word_o      // word taken from the device
);
	logic       sclk_reg;  // last shift clock level, for edge finding
	logic [4:0] bit_reg;   // bits already sent in this frame
	// count shift clock rises while frame sync is low and capture the device line on each such rise
	always_ff @(posedge mclk_i) begin
		sclk_reg <= sclk_i;
		if (frame_sync_n_i) begin
			bit_reg <= 5'h00;
		end else if (sclk_i && !sclk_reg) begin
			bit_reg   <= bit_reg + 5'h01;
			// an undriven line is captured as unknown so it never matches
			rx_word_o <= {rx_word_o[14:0], data_out_oe_i ? data_out_i : 1'bx};
		end
	end
	// msb set up before the frame, next bit just after each rise; inverse once done
	assign data_in_o = (bit_reg < 5'h10) ? tx_word_i[4'hF - bit_reg[3:0]] : ~tx_word_i[0];
endmodule
`default_nettype wire
